// File: sps_map.svh
// Constants for the status pin signal select block: codes, timing and reset values.
// How it works
// [RULE_01] Three pins, each with a six-bit select.
// [RULE_02] Code 07: packet checksum good, cleared on read.
// [RULE_03] Code 0A: lock detector, rising edge means lock.
// [RULE_04] Code 0B: serial clock, data changes on fall.
// [RULE_05] Code 0C: serial data aligned to serial clock.
// [RULE_06] Code 0D: raw receive data, no clock.
// [RULE_07] Code 0E: carrier sense, cleared in idle.
// [RULE_08] Code 0F: checksum match, cleared on receive start.
// [RULE_09] Host never programs the reserved test codes.
// [RULE_10] Code 1C: amplifier power-down, same in sleep; the code forces it in sleep like other codes below 20.
// [RULE_11] Code 2F: constant level set by invert.
// [RULE_12] Codes 30/31: divided clock, one pin only.
// [RULE_13] Host keeps other pins below 30 then.
// [RULE_14] Sleep forces codes below 20 to fixed levels.
// [RULE_15] Second pin drives only while chip select high.
// [RULE_16] Output is signal XOR invert; 2E releases driver.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// Select codes that the mux recognises.
`define SPS_CODE_PKT_CRC    6'h07
`define SPS_CODE_PLL_LOCK   6'h0A
`define SPS_CODE_SER_CLK    6'h0B
`define SPS_CODE_SER_DATA   6'h0C
`define SPS_CODE_ASYNC      6'h0D
`define SPS_CODE_CARRIER    6'h0E
`define SPS_CODE_CRC_MATCH  6'h0F
`define SPS_CODE_LOW_NOISE_AMP_POWERDOWN     6'h1C
`define SPS_CODE_SLEEP_LIM  6'h20
`define SPS_CODE_LOW_FREQ   6'h27
`define SPS_CODE_CHIP_RDY   6'h29
`define SPS_CODE_SETTLED    6'h2B
`define SPS_CODE_HIGH_Z     6'h2E
`define SPS_CODE_FORCED     6'h2F
`define SPS_CODE_DIV1       6'h30
`define SPS_CODE_DIV1P5     6'h31

// Serial bit timing: bit time in ns, clock period in ns, half bit in cycles (rounded up).
`define SPS_SER_BIT_NS      80
`define SPS_CLK_PERIOD_NS   10
`define SPS_SER_HALF_CYC    ((`SPS_SER_BIT_NS + 2 * `SPS_CLK_PERIOD_NS - 1) / (2 * `SPS_CLK_PERIOD_NS))

// Chip select reset value, divider last count and buffer depth.
`define SPS_CS_SYNC_RST     1'h1
`define SPS_DIV_LAST        2'h2
`define SPS_BUF_DEPTH       2'h2

`endif

// File: sps_pkg.sv
// Types shared by the status pin signal select modules.
package sps_pkg;

  // Pin signal select code.
  typedef logic [5:0] sps_sel_t;

  // Serial shifter states, Gray coded along idle, low, high.
  typedef enum logic [1:0]
  {
    SPS_SER_IDLE = 2'h0,
    SPS_SER_LOW  = 2'h1,
    SPS_SER_HIGH = 2'h3
  } sps_ser_state_t;

  // State of the two-entry buffer.
  typedef struct packed
  {
    logic [1:0] mem;       // Two stored bits.
    logic       wr;        // Write slot.
    logic       rd;        // Read slot.
    logic [1:0] cnt;       // Stored entries.
    logic       in_ready;  // Registered room flag.
  } sps_buf_state_t;

  // State of the crystal clock divider.
  typedef struct packed
  {
    logic [1:0] cnt;       // Phase within three cycles.
    logic       div1;      // Crystal clock image.
    logic       div1p5;    // Crystal clock over 1.5.
  } sps_div_state_t;

  // State of the top module.
  typedef struct packed
  {
    logic           cs_sync1;      // Chip select, first stage.
    logic           cs_sync2;      // Chip select, second stage.
    logic           lfc_sync1;     // Low frequency clock, first stage.
    logic           lfc_sync2;     // Low frequency clock, second stage.
    logic           pkt_flag;      // Packet received with good checksum.
    logic           carrier_flag;  // Carrier sense.
    logic           crc_flag;      // Last checksum matched.
    logic           sleep_hold;    // Sleep levels held until chip ready.
    sps_ser_state_t ser_state;     // Serial shifter state.
    logic [3:0]     ser_cnt;       // Half bit counter.
    logic           ser_clk;       // Serial clock.
    logic           ser_data;      // Serial data.
    logic [2:0]     pin_out;       // Pin levels.
    logic [2:0]     pin_oe;        // Pin drive enables.
  } sps_top_state_t;

endpackage : sps_pkg

// File: sps_buf2.sv
// Two-entry buffer for received serial bits, with valid and ready on both sides.
`timescale 1ns/1ns
`include "sps_map.svh"

module sps_buf2 (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic in_valid,
  output wire logic in_ready,
  input  wire logic in_data,
  output wire logic out_valid,
  input  wire logic out_ready,
  output wire logic out_data
);
  import sps_pkg::*;

  sps_buf_state_t st_r;   // Registered state.
  sps_buf_state_t st_nxt; // Next state.
  logic           push;   // Word accepted.
  logic           pop;    // Word delivered.

  // Room is registered so the source sees a flop; it is computed from the next count.
  assign in_ready  = st_r.in_ready;
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data  = st_r.mem[st_r.rd];
  assign push      = in_valid && st_r.in_ready;
  assign pop       = out_valid && out_ready;

  // Next state: store on push, advance on pop, track the count.
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr           = ~st_r.wr;
    end
    if (pop)
    begin
      st_nxt.rd = ~st_r.rd;
    end
    if (push && !pop)
    begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end
    else if (pop && !push)
    begin
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
    st_nxt.in_ready = (st_nxt.cnt != `SPS_BUF_DEPTH);
  end

  // State register; the buffer is empty and ready after reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r          <= '0;
      st_r.in_ready <= 1'h1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : sps_buf2

// File: sps_clkdiv.sv
// Divider that makes the crystal clock images for the divided clock codes.
`timescale 1ns/1ns
`include "sps_map.svh"

module sps_clkdiv (
  input  wire logic clk,
  input  wire logic rst,
  output wire logic div1,
  output wire logic div1p5
);
  import sps_pkg::*;

  sps_div_state_t st_r;   // Registered state.
  sps_div_state_t st_nxt; // Next state.

  assign div1   = st_r.div1;
  assign div1p5 = st_r.div1p5;

  // The crystal image toggles each cycle; the 1.5 image spans three cycles.
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.div1 = ~st_r.div1;
    if (st_r.cnt == `SPS_DIV_LAST)
    begin
      st_nxt.cnt = 2'h0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end
    st_nxt.div1p5 = (st_nxt.cnt != `SPS_DIV_LAST); // [RULE_12]
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : sps_clkdiv

// File: sps_status_pins.sv
// Top of the status pin signal select block: flags, serial shifter and per-pin muxes.
`timescale 1ns/1ns
`include "sps_map.svh"

module sps_status_pins (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire sps_pkg::sps_sel_t pin0_signal_select,
  input  wire sps_pkg::sps_sel_t pin1_signal_select,
  input  wire sps_pkg::sps_sel_t pin2_signal_select,
  input  wire logic          pin0_invert,
  input  wire logic          pin1_invert,
  input  wire logic          pin2_invert,
  input  wire logic          chip_select_n,
  input  wire logic          sleep_state,
  input  wire logic          chip_ready_n,
  input  wire logic          crystal_settled,
  input  wire logic          low_freq_clock,
  input  wire logic          pkt_crc_good,
  input  wire logic          rx_first_byte_read,
  input  wire logic          pll_lock,
  input  wire logic          rx_bit_valid,
  input  wire logic          rx_bit,
  output wire logic          rx_bit_ready,
  input  wire logic          async_rx_data,
  input  wire logic          signal_strength_above,
  input  wire logic          radio_idle,
  input  wire logic          crc_check_done,
  input  wire logic          crc_check_match,
  input  wire logic          rx_mode_start,
  input  wire logic          low_noise_amp_powerdown,
  output wire logic [2:0]    status_pin_out,
  output wire logic [2:0]    status_pin_oe
);
  import sps_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------

  sps_top_state_t st_r;      // Registered state of the whole module.
  sps_top_state_t st_nxt;    // Next value of the state.
  sps_sel_t [2:0] sel_v;     // Select codes gathered by pin index.
  logic [2:0]     inv_v;     // Invert bits gathered by pin index.
  logic [2:0]     is_clk;    // Pin asks for a divided crystal clock.
  logic [2:0]     pin_val;   // Level each pin would present next.
  logic [2:0]     pin_en;    // Drive enable each pin would have next.
  logic           buf_valid; // Buffer holds a bit for the shifter.
  logic           buf_data;  // Oldest buffered bit.
  logic           ser_take;  // Shifter takes the oldest bit.
  logic           div1;      // Crystal clock image.
  logic           div1p5;    // Crystal clock over 1.5.
  logic [3:0]     half_last; // Last count of a half bit.

  assign sel_v     = {pin2_signal_select, pin1_signal_select, pin0_signal_select};
  assign inv_v     = {pin2_invert, pin1_invert, pin0_invert};
  assign half_last = 4'(`SPS_SER_HALF_CYC - 1);

  // Every pin output comes straight from the state flops.
  assign status_pin_out = st_r.pin_out;
  assign status_pin_oe  = st_r.pin_oe;

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------

  // The buffer absorbs bits while the shifter is mid-bit, so a stall loses nothing.
  sps_buf2 u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_bit_valid),
    .in_ready  (rx_bit_ready),
    .in_data   (rx_bit),
    .out_valid (buf_valid),
    .out_ready (ser_take),
    .out_data  (buf_data)
  );

  // Free running divider for the divided crystal clock codes.
  sps_clkdiv u_div (
    .clk    (clk),
    .rst    (rst),
    .div1   (div1),
    .div1p5 (div1p5)
  );

  // ------------------------------------------------------------------
  // Per-pin signal muxes
  // ------------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_pin
      logic blk;    // A lower pin already owns the divided clock.
      logic raw;    // Selected signal before inversion.
      logic drive;  // Pin driver enabled.
      logic forced; // Sleep forces a fixed level.

      // Flag a divided clock request on this pin.
      assign is_clk[gi] = (sel_v[gi] == `SPS_CODE_DIV1) || (sel_v[gi] == `SPS_CODE_DIV1P5);

      // Only the lowest requesting pin gets the clock; the others stay quiet.
      if (gi == 0)
      begin : g_first
        assign blk = 1'h0;
      end
      else
      begin : g_rest
        assign blk = |is_clk[gi-1:0]; // [RULE_12]
      end

      // Pick the internal signal named by the select code.
      always_comb
      begin
        raw   = 1'h0;
        drive = 1'h1;
        case (sel_v[gi]) // [RULE_01]
          `SPS_CODE_PKT_CRC:   raw = st_r.pkt_flag;         // [RULE_02]
          `SPS_CODE_PLL_LOCK:  raw = pll_lock;              // [RULE_03]
          `SPS_CODE_SER_CLK:   raw = st_r.ser_clk;          // [RULE_04]
          `SPS_CODE_SER_DATA:  raw = st_r.ser_data;         // [RULE_05]
          `SPS_CODE_ASYNC:     raw = async_rx_data;         // [RULE_06]
          `SPS_CODE_CARRIER:   raw = st_r.carrier_flag;     // [RULE_07]
          `SPS_CODE_CRC_MATCH: raw = st_r.crc_flag;         // [RULE_08]
          `SPS_CODE_LOW_NOISE_AMP_POWERDOWN:    raw = low_noise_amp_powerdown; // [RULE_10]
          `SPS_CODE_LOW_FREQ:  raw = st_r.lfc_sync2;
          `SPS_CODE_CHIP_RDY:  raw = chip_ready_n;
          `SPS_CODE_SETTLED:   raw = crystal_settled;
          `SPS_CODE_HIGH_Z:    drive = 1'h0;                // [RULE_16]
          `SPS_CODE_FORCED:    raw = 1'h0;                  // [RULE_11]
          `SPS_CODE_DIV1:      raw = div1 && !blk;          // [RULE_12]
          `SPS_CODE_DIV1P5:    raw = div1p5 && !blk;        // [RULE_12]
          // Reserved test codes select a low signal before inversion; the host keeps away from them.
          default:             raw = 1'h0;                  // [RULE_09]
        endcase
      end

      // Sleep pins with low codes; the second pin rests at the opposite level.
      assign forced = st_r.sleep_hold && (sel_v[gi] < `SPS_CODE_SLEEP_LIM); // [RULE_14]

      // Combine inversion, sleep levels and the chip select gate on the second pin.
      always_comb
      begin
        if (forced)
        begin
          pin_val[gi] = (gi == 1) ? !inv_v[gi] : inv_v[gi]; // [RULE_14]
          pin_en[gi]  = 1'h1;
        end
        else
        begin
          pin_val[gi] = raw ^ inv_v[gi]; // [RULE_16]
          pin_en[gi]  = drive;
        end
        if (gi == 1)
        begin
          // The serial port owns this pin while chip select is low.
          pin_en[gi] = pin_en[gi] && st_r.cs_sync2; // [RULE_15]
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------

  // One process computes every flag, the shifter and the pin flops.
  always_comb
  begin
    st_nxt   = st_r;
    ser_take = 1'h0;

    // Pin inputs from outside the clock domain pass two flops first.
    st_nxt.cs_sync1  = chip_select_n;
    st_nxt.cs_sync2  = st_r.cs_sync1;
    st_nxt.lfc_sync1 = low_freq_clock;
    st_nxt.lfc_sync2 = st_r.lfc_sync1;

    // Packet flag: a new packet in the cycle of the read keeps the flag set.
    if (pkt_crc_good)
    begin
      st_nxt.pkt_flag = 1'h1; // [RULE_02]
    end
    else if (rx_first_byte_read)
    begin
      st_nxt.pkt_flag = 1'h0; // [RULE_02]
    end

    // Carrier sense follows the threshold but is held low in idle.
    st_nxt.carrier_flag = signal_strength_above && !radio_idle; // [RULE_07]

    // Checksum match: a fresh comparison wins over the receive restart.
    if (crc_check_done)
    begin
      st_nxt.crc_flag = crc_check_match; // [RULE_08]
    end
    else if (rx_mode_start)
    begin
      st_nxt.crc_flag = 1'h0; // [RULE_08]
    end

    // Sleep levels stay until the chip reports ready again.
    if (sleep_state)
    begin
      st_nxt.sleep_hold = 1'h1; // [RULE_14]
    end
    else if (!chip_ready_n)
    begin
      st_nxt.sleep_hold = 1'h0; // [RULE_14]
    end

    // Serial shifter: data changes with the clock's fall, so the sampler
    // can take it on the rise with half a bit of margin.
    case (st_r.ser_state)
      SPS_SER_IDLE:
      begin
        st_nxt.ser_clk = 1'h0;
        if (buf_valid)
        begin
          ser_take         = 1'h1;
          st_nxt.ser_data  = buf_data; // [RULE_05]
          st_nxt.ser_cnt   = 4'h0;
          st_nxt.ser_state = SPS_SER_LOW;
        end
      end
      SPS_SER_LOW:
      begin
        if (st_r.ser_cnt == half_last)
        begin
          st_nxt.ser_cnt   = 4'h0;
          st_nxt.ser_clk   = 1'h1; // [RULE_04]
          st_nxt.ser_state = SPS_SER_HIGH;
        end
        else
        begin
          st_nxt.ser_cnt = st_r.ser_cnt + 4'h1;
        end
      end
      SPS_SER_HIGH:
      begin
        if (st_r.ser_cnt == half_last)
        begin
          st_nxt.ser_cnt = 4'h0;
          st_nxt.ser_clk = 1'h0; // [RULE_04]
          if (buf_valid)
          begin
            // Next bit goes out on the same edge as the falling clock.
            ser_take         = 1'h1;
            st_nxt.ser_data  = buf_data; // [RULE_04]
            st_nxt.ser_state = SPS_SER_LOW;
          end
          else
          begin
            st_nxt.ser_state = SPS_SER_IDLE;
          end
        end
        else
        begin
          st_nxt.ser_cnt = st_r.ser_cnt + 4'h1;
        end
      end
      default:
      begin
        st_nxt.ser_state = SPS_SER_IDLE;
        st_nxt.ser_clk   = 1'h0;
      end
    endcase

    // Pins register the mux result, which costs one cycle of latency.
    st_nxt.pin_out = pin_val;
    st_nxt.pin_oe  = pin_en;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------

  // Pins are released during reset; chip select reads as deasserted.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r          <= '0;
      st_r.cs_sync1 <= `SPS_CS_SYNC_RST;
      st_r.cs_sync2 <= `SPS_CS_SYNC_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : sps_status_pins

// File: sps_status_pins_sva.sv
// Checker of the status pin signal select block, bound to its top module.
`timescale 1ns/1ns

module sps_status_pins_sva (
  input wire logic              clk,
  input wire logic              rst,
  input wire sps_pkg::sps_sel_t pin0_signal_select,
  input wire sps_pkg::sps_sel_t pin2_signal_select,
  input wire logic              pin0_invert,
  input wire logic              pin2_invert,
  input wire logic              chip_select_n,
  input wire logic              sleep_state,
  input wire logic              chip_ready_n,
  input wire logic              pkt_crc_good,
  input wire logic              pll_lock,
  input wire logic              crc_check_done,
  input wire logic              crc_check_match,
  input wire logic [2:0]        status_pin_out,
  input wire logic [2:0]        status_pin_oe
);
  import sps_pkg::*;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [1:0] awake_r;  // Cycles in a row out of sleep with the chip ready.
  logic       awake;    // The sleep hold is surely released.
  logic       ser_ok;   // Serial clock on pin 0 and serial data on pin 2, not inverted.

  // The hold lags sleep by a cycle, so two quiet cycles are needed before pins are trusted.
  always_ff @(posedge clk)
  begin
    if (rst || sleep_state || chip_ready_n)
      awake_r <= 2'h0;
    else if (awake_r != 2'h3)
      awake_r <= awake_r + 2'h1;
  end

  assign awake  = awake_r[1] && !sleep_state && !chip_ready_n;
  assign ser_ok = awake && pin0_signal_select == 6'h0B && pin2_signal_select == 6'h0C
                  && !pin0_invert && !pin2_invert;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_hiz;
    pin0_signal_select == 6'h2E |=> !status_pin_oe[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin 0 drives while released");

  property p_forced;
    pin2_signal_select == 6'h2F |=> status_pin_oe[2] && status_pin_out[2] == $past(pin2_invert);
  endproperty
  a_forced: assert property (p_forced) else $error("pin 2 forced level wrong");

  property p_lock;
    awake && pin0_signal_select == 6'h0A
      |=> status_pin_out[0] == ($past(pll_lock) ^ $past(pin0_invert));
  endproperty
  a_lock: assert property (p_lock) else $error("pin 0 lock level wrong");

  property p_sleep;
    sleep_state ##1 (sleep_state && pin0_signal_select < 6'h20)
      |=> status_pin_out[0] == $past(pin0_invert);
  endproperty
  a_sleep: assert property (p_sleep) else $error("pin 0 not held in sleep");

  property p_cs;
    !chip_select_n [*4] |=> !status_pin_oe[1];
  endproperty
  a_cs: assert property (p_cs) else $error("pin 1 drives while selected");

  property p_pkt;
    pkt_crc_good ##1 (awake && pin0_signal_select == 6'h07)
      |=> status_pin_out[0] != $past(pin0_invert);
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet flag not shown");

  property p_crc;
    crc_check_done ##1 (awake && pin2_signal_select == 6'h0F)
      |=> status_pin_out[2] == ($past(crc_check_match, 2) ^ $past(pin2_invert));
  endproperty
  a_crc: assert property (p_crc) else $error("checksum flag wrong");

  property p_div;
    (pin0_signal_select == 6'h30 && !pin0_invert) [*3]
      |=> status_pin_out[0] != $past(status_pin_out[0]);
  endproperty
  a_div: assert property (p_div) else $error("divided clock did not toggle");

  property p_ser;
    $changed(status_pin_out[2]) && $past(ser_ok) && $past(ser_ok, 2) |-> !status_pin_out[0];
  endproperty
  a_ser: assert property (p_ser) else $error("serial data moved while clock high");

endmodule : sps_status_pins_sva

bind sps_status_pins sps_status_pins_sva u_sva (
  .clk, .rst, .pin0_signal_select, .pin2_signal_select, .pin0_invert, .pin2_invert,
  .chip_select_n, .sleep_state, .chip_ready_n, .pkt_crc_good, .pll_lock,
  .crc_check_done, .crc_check_match, .status_pin_out, .status_pin_oe
);

// File: sps_host_model.sv
// Host side model: resolves the pins, takes serial bits and counts lock interrupts.
`timescale 1ns/1ns

module sps_host_model (
  input  wire logic       clk,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  output wire logic [2:0] pin_level,
  output var  logic [7:0] rx_shift,
  output var  logic [7:0] rx_bits,
  output var  logic [7:0] irq_count
);
  logic [2:0] last_r;  // Level seen at the previous edge.

  // A released pin shows the inverse of its last level, so a stale value never passes.
  assign pin_level = (pin_out & pin_oe) | (~last_r & ~pin_oe);

  initial
  begin
    last_r    = 3'h0;
    rx_shift  = 8'h00;
    rx_bits   = 8'h00;
    irq_count = 8'h00;
  end

  // Bits are taken on the rising serial clock, where the data has settled.
  always @(posedge clk)
  begin
    last_r <= pin_level;
    if (pin_level[0] && !last_r[0])
    begin
      rx_shift <= {rx_shift[6:0], pin_level[2]};
      rx_bits  <= rx_bits + 8'h01;
    end
    if (pin_level[2] && !last_r[2])
      irq_count <= irq_count + 8'h01;
  end

endmodule : sps_host_model

// File: sps_status_pins_tb.sv
// Self-checking testbench of the status pin signal select block.
`timescale 1ns/1ns

module sps_status_pins_tb;
  import sps_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  sps_sel_t   sel [3];
  logic [2:0] inv, pout, poe, lvl;
  logic       cs_n, sleep, rdy_n, settled, pkt, rd1, lock, bv, rbit, bready;
  logic       async, signal_strength, idle, cdone, cmatch, rxs, lna, full, lfc;
  logic [7:0] h_shift, h_bits, h_irq;
  int         n_mismatch = 0;
  int         checked = 0;

  always #5 clk = ~clk;

  // Every input of the block is driven by the scenarios below.
  sps_status_pins DUT (
    .clk(clk), .rst(rst), .pin0_signal_select(sel[0]), .pin1_signal_select(sel[1]),
    .pin2_signal_select(sel[2]), .pin0_invert(inv[0]), .pin1_invert(inv[1]),
    .pin2_invert(inv[2]), .chip_select_n(cs_n), .sleep_state(sleep), .chip_ready_n(rdy_n),
    .crystal_settled(settled), .low_freq_clock(lfc), .pkt_crc_good(pkt),
    .rx_first_byte_read(rd1), .pll_lock(lock), .rx_bit_valid(bv), .rx_bit(rbit),
    .rx_bit_ready(bready), .async_rx_data(async), .signal_strength_above(signal_strength),
    .radio_idle(idle), .crc_check_done(cdone), .crc_check_match(cmatch),
    .rx_mode_start(rxs), .low_noise_amp_powerdown(lna), .status_pin_out(pout),
    .status_pin_oe(poe)
  );

  sps_host_model u_host (
    .clk(clk), .pin_out(pout), .pin_oe(poe), .pin_level(lvl),
    .rx_shift(h_shift), .rx_bits(h_bits), .irq_count(h_irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Inputs always move 1 ns after an edge, never on it.
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Every plain level code except 27, plus 2F and 2E, on all pins, both invert settings, both source levels.
  task automatic t_levels();
    sps_sel_t codes [7] = '{6'h0A, 6'h0D, 6'h1C, 6'h29, 6'h2B, 6'h2F, 6'h2E};
    for (int c = 0; c < 7; c++)
      for (int k = 0; k < 4; k++)
      begin
        sel = '{codes[c], codes[c], codes[c]};
        inv = {3{k[0]}};
        {lock, async, lna, settled} = {4{k[1]}};
        rdy_n = (codes[c] == 6'h29) && k[1];
        step(1);
        if (codes[c] != 6'h2E)
          check("level", pout, (codes[c] == 6'h2F) ? inv : ({3{k[1]}} ^ inv));
        check("enable", poe, (codes[c] == 6'h2E) ? 3'h0 : 3'h7);
      end
  endtask : t_levels

  // Event table {pkt, read, done, match, restart, strength, idle} with pins {crc, carrier, pkt}.
  task automatic t_flags();
    logic [6:0] ev [7] = '{7'h42, 7'h63, 7'h20, 7'h1A, 7'h04, 7'h1C, 7'h10};
    logic [2:0] ex [7] = '{3'h3, 3'h1, 3'h0, 3'h6, 3'h0, 3'h4, 3'h0};
    sel = '{6'h07, 6'h0E, 6'h0F};
    inv = 3'h0;
    for (int i = 0; i < 7; i++)
    begin
      {pkt, rd1, cdone, cmatch, rxs, signal_strength, idle} = ev[i];
      step(1);
      {pkt, rd1, cdone, cmatch, rxs, signal_strength, idle} = '0;
      step(1);
      check("flags", pout, ex[i]);
    end
  endtask : t_flags

  task automatic t_cs();
    sel = '{6'h27, 6'h2F, 6'h2F};
    inv = 3'h7;
    lfc = 1'b1;
    cs_n = 1'b0;
    step(4);
    check("select low enable", poe, 3'h5);
    cs_n = 1'b1;
    step(4);
    check("select high pins", {poe, pout}, 8'h3E);
  endtask : t_cs

  // Held levels last until the chip is ready again, not merely until sleep ends.
  task automatic t_sleep();
    sel = '{6'h0A, 6'h0A, 6'h2F};
    inv = 3'h4;
    lock = 1'b0;
    sleep = 1'b1;
    rdy_n = 1'b1;
    step(3);
    check("sleep hold", pout, 3'h6);
    sleep = 1'b0;
    step(3);
    check("hold until ready", pout, 3'h6);
    rdy_n = 1'b0;
    step(3);
    check("released", {poe, pout}, 8'h3C);
  endtask : t_sleep

  task automatic t_div();
    logic       p;
    logic [5:0] s;
    sel = '{6'h30, 6'h2F, 6'h2F};
    inv = 3'h0;
    step(3);
    for (int i = 0; i < 4; i++)
    begin
      p = pout[0];
      step(1);
      check("div one", pout[0], !p);
    end
    sel = '{6'h2F, 6'h2F, 6'h31};
    step(3);
    for (int i = 0; i < 6; i++)
    begin
      s[i] = pout[2];
      step(1);
    end
    check("div 1.5 first", 8'($countones(s[2:0])), 8'h02);
    check("div 1.5 second", 8'($countones(s[5:3])), 8'h02);
  endtask : t_div

  task automatic t_lock();
    logic [7:0] c0;
    sel = '{6'h2F, 6'h2F, 6'h0A};
    lock = 1'b0;
    step(2);
    c0 = h_irq;
    repeat (2)
    begin
      lock = 1'b1;
      step(2);
      lock = 1'b0;
      step(2);
    end
    check("lock edges", h_irq - c0, 8'h02);
  endtask : t_lock

  // Bits are offered back to back, so the buffer fills and must stall the sender.
  task automatic t_serial();
    logic [7:0] b0;
    sel = '{6'h0B, 6'h2F, 6'h0C};
    b0 = h_bits;
    full = 1'b0;
    bv = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      rbit = 1'(8'hA5 >> i);
      for (int w = 0; w < 100 && !bready; w++)
      begin
        full = 1'b1;
        step(1);
      end
      step(1);
    end
    bv = 1'b0;
    for (int w = 0; w < 300 && h_bits != b0 + 8'h08; w++)
      step(1);
    check("serial byte", h_shift, 8'hA5);
    check("buffer stalled", full, 1'b1);
    check("buffer drained", bready, 1'b1);
  endtask : t_serial

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    sel = '{6'h2F, 6'h2F, 6'h2F};
    {inv, sleep, rdy_n, settled, pkt, rd1, lock, bv, rbit} = '0;
    {async, signal_strength, idle, cdone, cmatch, rxs, lna, full, lfc} = '0;
    cs_n = 1'b1;
    step(3);
    check("reset pins", {poe, pout, bready}, 8'h01);
    rst = 1'b0;
    t_levels();
    t_flags();
    t_cs();
    t_sleep();
    t_div();
    t_lock();
    t_serial();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

endmodule : sps_status_pins_tb
